// [design/spa_engine.sv]
// spa_engine: state histogram and time interval statistics engine
// assumes samples arrive already on clk, one per cycle at most, and a
// register master that never issues read and write in the same cycle
`timescale 1ns/100ps
`default_nettype none

module spa_engine
    import spa_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst_n,
    input  wire bus_req_t req,
    input  wire smp_t     smp,
    output logic [31:0]   rdata,
    output logic          busy,
    output logic          halted
);
    engine_t         s;
    engine_t         n;
    logic [LW-1:0]   lab;
    logic            qok;
    logic            acc;
    logic            tsmp;
    logic            stm;
    logic            enm;
    logic            pair;
    logic            stored;
    logic            endacq;
    logic            crit;
    logic            run_cmd;
    logic            lg;
    logic [NHR-1:0]  hit;
    logic [NIR-1:0]  ion;
    logic [NIR-1:0]  shared;
    logic [NIR-1:0]  ihit;
    logic [TW-1:0]   dur;
    logic [TW-1:0]   dq;
    logic [TW-1:0]   span;
    logic [TW-1:0]   step;
    logic [TW-1:0]   alo;
    logic [TW-1:0]   ahi;
    logic [64:0]     sx;

    function automatic logic pmatch(input logic [LW-1:0] d, input logic [LW-1:0] v,
                                    input logic [LW-1:0] c);
        return ((d ^ v) & c) == '0;
    endfunction
    function automatic logic [CW-1:0] sinc(input logic [CW-1:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction
    function automatic logic at(input logic [AW-1:0] a, input logic [AW-1:0] base,
                                input int idx, input int stride, input int k);
        return a == AW'(int'(base) + idx * stride + k * WORD);
    endfunction
    always_comb begin
        n       = s;
        n.rdata = '0;
        alo     = '0;
        ahi     = '0;
        lg      = req.wdata[CT_LOG];
        crit    = 1'b0;
        run_cmd = req.wr && req.addr == CTRL_OFF && req.wdata[CT_RUN];
        lab     = (smp.data >> s.cfg[CF_SH +: SH_W]) & s.lmask;
        // qualifier spans every label, not only the histogram one
        qok     = !s.cfg[CF_QUAL] || pmatch(smp.data, s.qv, s.qc);
        for (int i = 0; i < NHR; i++) begin
            hit[i] = s.hen[i] && lab >= s.hlo[i] && lab <= s.hhi[i];
        end
        acc    = s.st == ST_ACQ && smp.valid && !s.cfg[CF_MODE] && qok;
        tsmp   = s.st == ST_ACQ && smp.valid && s.cfg[CF_MODE] && !s.cfg[CF_HALF];
        stm    = pmatch(smp.data, s.sv, s.sc);
        enm    = pmatch(smp.data, s.ev, s.ec);
        pair   = tsmp && s.timing && enm;
        dur    = s.tt - s.t0;
        dq     = dur & STAT_MASK;
        for (int i = 0; i < NIR; i++) begin
            ion[i] = s.ilo[i] != '0 || s.ihi[i] != '0;
        end
        for (int i = 0; i < NIR; i++) begin
            shared[i] = 1'b0;
            for (int j = 0; j < NIR; j++) begin
                if (j != i && ion[j] && s.ilo[j] == s.ihi[i]) begin
                    shared[i] = 1'b1;
                end
            end
            // upper limit is inclusive unless another range starts there
            ihit[i] = ion[i] && dur >= s.ilo[i]
                      && (dur < s.ihi[i] || (dur == s.ihi[i] && !shared[i]));
        end
        stored = acc || tsmp;
        endacq = stored && s.nsmp == (s.cfg[CF_HALF] ? NW'(ACQ_DEPTH_HALF - 1) : NW'(ACQ_DEPTH - 1));
        sx     = {1'b0, s.sum} + 65'(dq);
        span   = s.armax - s.armin;
        step   = lg ? span >> AR_LOG_SH : span >> AR_LIN_SH;
        if (step < AR_STEP) begin
            step = AR_STEP;
        end

        unique case (s.st)
            ST_IDLE: n.timing = 1'b0;
            ST_ACQ: begin
                n.tt = s.tt + TT_INC;
                if (stored) begin
                    n.nsmp = s.nsmp + 1'b1;
                end
                if (endacq) begin
                    n.st = ST_COMMIT;
                end
            end
            ST_COMMIT: begin
                // memory full: publish the pair count and rearm at once
                n.itot   = s.ipend;
                n.st     = ST_ACQ;
                n.tt     = '0;
                n.nsmp   = '0;
                n.timing = 1'b0;
            end
            default: n.st = ST_IDLE;
        endcase
        if (acc) begin
            for (int i = 0; i < NHR; i++) begin
                if (hit[i]) begin
                    n.hc[i] = sinc(s.hc[i]);
                end
            end
            if (|hit) begin
                n.htot = sinc(s.htot);
            end else begin
                n.oth = sinc(s.oth);
                if (s.cfg[CF_OTH]) begin
                    n.htot = sinc(s.htot);
                end
            end
        end
        if (tsmp) begin
            if (!s.timing && stm) begin
                n.timing = 1'b1;
                n.t0     = s.tt;
            end else if (pair) begin
                n.timing = 1'b0;
                for (int i = 0; i < NIR; i++) begin
                    if (ihit[i]) begin
                        n.ic[i] = sinc(s.ic[i]);
                    end
                end
                n.ipend = sinc(s.ipend);
                if (dq < s.mn) begin
                    n.mn = dq;
                end
                if (dq > s.mx) begin
                    n.mx = dq;
                end
                n.sum = sx[64] ? '1 : sx[63:0];
            end
        end
        if (req.wr) begin
            case (req.addr)
                CFG_OFF: begin
                    n.cfg = req.wdata;
                    crit  = req.wdata != s.cfg;
                end
                LMASK_OFF: begin
                    n.lmask = req.wdata;
                    crit    = req.wdata != s.lmask;
                end
                QVAL_OFF: begin
                    n.qv = req.wdata;
                    crit = req.wdata != s.qv;
                end
                QCARE_OFF: begin
                    n.qc = req.wdata;
                    crit = req.wdata != s.qc;
                end
                SVAL_OFF: begin
                    n.sv = req.wdata;
                    crit = req.wdata != s.sv;
                end
                SCARE_OFF: begin
                    n.sc = req.wdata;
                    crit = req.wdata != s.sc;
                end
                EVAL_OFF: begin
                    n.ev = req.wdata;
                    crit = req.wdata != s.ev;
                end
                ECARE_OFF: begin
                    n.ec = req.wdata;
                    crit = req.wdata != s.ec;
                end
                HEN_OFF: n.hen = req.wdata[NHR-1:0];
                ARMIN_OFF: n.armin[31:0] = req.wdata;
                ARMAX_OFF: n.armax[31:0] = req.wdata;
                default: ;
            endcase
            if (at(req.addr, ARMIN_OFF, 0, 0, 1)) begin
                n.armin[TW-1:32] = req.wdata[TW-33:0];
            end
            if (at(req.addr, ARMAX_OFF, 0, 0, 1)) begin
                n.armax[TW-1:32] = req.wdata[TW-33:0];
            end
            for (int i = 0; i < NHR; i++) begin
                if (at(req.addr, HR_BASE, i, HR_STRIDE, 0)) begin
                    n.hlo[i] = req.wdata;
                end
                if (at(req.addr, HR_BASE, i, HR_STRIDE, 1)) begin
                    n.hhi[i] = req.wdata;
                end
            end
            for (int i = 0; i < NIR; i++) begin
                if (at(req.addr, IR_BASE, i, IR_STRIDE, 0)) begin
                    n.ilo[i][31:0] = req.wdata;
                end
                if (at(req.addr, IR_BASE, i, IR_STRIDE, 1)) begin
                    n.ilo[i][TW-1:32] = req.wdata[TW-33:0];
                end
                if (at(req.addr, IR_BASE, i, IR_STRIDE, 2)) begin
                    n.ihi[i][31:0] = req.wdata;
                end
                if (at(req.addr, IR_BASE, i, IR_STRIDE, 3)) begin
                    n.ihi[i][TW-1:32] = req.wdata[TW-33:0];
                end
            end
            if (crit && s.st != ST_IDLE) begin
                n.st     = ST_IDLE;
                n.halted = 1'b1;
                n.timing = 1'b0;
            end
            if (req.addr == CTRL_OFF) begin
                if (req.wdata[CT_STOP] && s.st != ST_IDLE) begin
                    n.itot   = n.ipend;
                    n.st     = ST_IDLE;
                    n.timing = 1'b0;
                end
                if (req.wdata[CT_AUTO]) begin
                    for (int i = 0; i < NIR; i++) begin
                        alo = lg ? s.armin + ((step << i) - step) : s.armin + TW'(i) * step;
                        ahi = lg ? s.armin + ((step << (i + 1)) - step) : alo + step;
                        // ranges that do not fit below max are dropped from the top
                        if (ahi > s.armax || (s.armin == '0 && s.armax == '0)) begin
                            n.ilo[i] = '0;
                            n.ihi[i] = '0;
                        end else begin
                            n.ilo[i] = alo;
                            n.ihi[i] = ahi;
                        end
                    end
                end
                if (run_cmd) begin
                    n.hc     = '0;
                    n.ic     = '0;
                    n.oth    = '0;
                    n.htot   = '0;
                    n.itot   = '0;
                    n.ipend  = '0;
                    n.mn     = '1;
                    n.mx     = '0;
                    n.sum    = '0;
                    n.halted = 1'b0;
                    n.st     = ST_ACQ;
                    n.tt     = '0;
                    n.nsmp   = '0;
                    n.timing = 1'b0;
                end
            end
        end

        if (req.rd) begin
            case (req.addr)
                CFG_OFF:   n.rdata = s.cfg;
                LMASK_OFF: n.rdata = s.lmask;
                QVAL_OFF:  n.rdata = s.qv;
                QCARE_OFF: n.rdata = s.qc;
                SVAL_OFF:  n.rdata = s.sv;
                SCARE_OFF: n.rdata = s.sc;
                EVAL_OFF:  n.rdata = s.ev;
                ECARE_OFF: n.rdata = s.ec;
                HEN_OFF:   n.rdata = 32'(s.hen);
                STAT_OFF:  n.rdata = 32'({s.halted, s.timing, s.st});
                HTOT_OFF:  n.rdata = s.htot;
                OTH_OFF:   n.rdata = s.oth;
                ITOT_OFF:  n.rdata = s.itot;
                MIN_OFF:   n.rdata = s.mn[31:0];
                MAX_OFF:   n.rdata = s.mx[31:0];
                SUM_OFF:   n.rdata = s.sum[31:0];
                ARMIN_OFF: n.rdata = s.armin[31:0];
                ARMAX_OFF: n.rdata = s.armax[31:0];
                default: ;
            endcase
            if (at(req.addr, MIN_OFF, 0, 0, 1)) n.rdata = 32'(s.mn[TW-1:32]);
            if (at(req.addr, MAX_OFF, 0, 0, 1)) n.rdata = 32'(s.mx[TW-1:32]);
            if (at(req.addr, SUM_OFF, 0, 0, 1)) n.rdata = s.sum[63:32];
            if (at(req.addr, ARMIN_OFF, 0, 0, 1)) n.rdata = 32'(s.armin[TW-1:32]);
            if (at(req.addr, ARMAX_OFF, 0, 0, 1)) n.rdata = 32'(s.armax[TW-1:32]);
            for (int i = 0; i < NHR; i++) begin
                if (at(req.addr, HR_BASE, i, HR_STRIDE, 0)) n.rdata = s.hlo[i];
                if (at(req.addr, HR_BASE, i, HR_STRIDE, 1)) n.rdata = s.hhi[i];
                if (at(req.addr, HC_BASE, i, WORD, 0)) n.rdata = s.hc[i];
            end
            for (int i = 0; i < NIR; i++) begin
                if (at(req.addr, IR_BASE, i, IR_STRIDE, 0)) n.rdata = s.ilo[i][31:0];
                if (at(req.addr, IR_BASE, i, IR_STRIDE, 1)) n.rdata = 32'(s.ilo[i][TW-1:32]);
                if (at(req.addr, IR_BASE, i, IR_STRIDE, 2)) n.rdata = s.ihi[i][31:0];
                if (at(req.addr, IR_BASE, i, IR_STRIDE, 3)) n.rdata = 32'(s.ihi[i][TW-1:32]);
                if (at(req.addr, IC_BASE, i, WORD, 0)) n.rdata = s.ic[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s       <= '0;
            s.mn    <= '1;
            s.lmask <= LMASK_RST;
        end else begin
            s <= n;
        end
    end

    assign rdata  = s.rdata;
    assign busy   = s.st[0];
    assign halted = s.halted;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    range_count_a: assert property (
        acc && hit[0] && !(&s.hc[0]) && !run_cmd |=> s.hc[0] == $past(s.hc[0]) + 1'b1)
        else $error("enabled range missed an inside sample");
    overlap_both_a: assert property (
        acc && hit[0] && hit[1] && !(&s.hc[0]) && !(&s.hc[1]) && !run_cmd
        |=> s.hc[0] != $past(s.hc[0]) && s.hc[1] != $past(s.hc[1]))
        else $error("overlapping ranges not both counted");
    total_once_a: assert property (
        acc && (|hit) && !(&s.htot) && !run_cmd |=> s.htot == $past(s.htot) + 1'b1)
        else $error("histogram total not counted once");
    other_bin_a: assert property (
        acc && hit == '0 && !(&s.oth) && !run_cmd |=> s.oth == $past(s.oth) + 1'b1)
        else $error("unranged sample missed other bin");
    qual_drop_a: assert property (
        s.st == ST_ACQ && smp.valid && !s.cfg[CF_MODE] && !qok && !req.wr
        |=> $stable(s.oth) && $stable(s.htot) && $stable(s.nsmp))
        else $error("unqualified sample was kept");
    first_start_a: assert property (
        tsmp && s.timing && !enm && !req.wr |=> $stable(s.t0) && s.timing)
        else $error("later start restarted timing");
    shared_edge_a: assert property (
        pair && dur == s.ihi[0] && shared[0] && !run_cmd |=> $stable(s.ic[0]))
        else $error("shared boundary counted in lower range");
    zero_range_a: assert property (
        pair && !ion[0] && !run_cmd |=> $stable(s.ic[0]))
        else $error("zero range counted");
    total_hold_a: assert property (
        s.st == ST_ACQ && !req.wr |=> $stable(s.itot))
        else $error("pair total changed mid acquisition");
    half_off_a: assert property (
        s.cfg[CF_HALF] |-> !s.timing ##1 !s.timing)
        else $error("interval timing in half-channel mode");
    halt_flag_a: assert property (
        req.wr && req.addr == CFG_OFF && req.wdata != s.cfg && s.st == ST_ACQ
        |=> s.halted && s.st == ST_IDLE)
        else $error("setting change did not halt run");
    auto_off_a: assert property (
        req.wr && req.addr == CTRL_OFF && req.wdata[CT_AUTO] && !req.wdata[CT_LOG]
        && s.armin == '0 && s.armax == '0 |=> s.ilo == '0 && s.ihi == '0)
        else $error("zero auto-range left ranges on");

    overlap_c: cover property (acc && hit[0] && hit[1]);
    pair_c:    cover property (pair && (|ihit));
    halt_c:    cover property (s.st == ST_ACQ ##1 s.halted);
    commit_c:  cover property (s.st == ST_COMMIT ##1 s.st == ST_ACQ);
endmodule

`default_nettype wire

// [design/spa_pkg.sv]
// spa_pkg: constants, register map and carriers of the state statistics engine
// assumes a 100 MHz state clock and a plain strobe register port
package spa_pkg;
    localparam int CLK_NS         = 10;
    localparam int TW             = 54;    // ns, holds 9,999,999 s
    localparam int CW             = 32;
    localparam int LW             = 32;
    localparam int NHR            = 11;
    localparam int NIR            = 8;
    localparam int AW             = 9;
    localparam int NW             = 14;
    localparam int ACQ_DEPTH      = 4096;
    localparam int ACQ_DEPTH_HALF = 8192;
    localparam int AR_STEP_NS     = 10;
    localparam int AR_LIN_SH      = 3;     // eight equal steps
    localparam int AR_LOG_SH      = 8;     // widths 1+2+..+128 = 255 units
    localparam int STAT_RES_NS    = 8;
    localparam int HR_STRIDE      = 8;
    localparam int IR_STRIDE      = 16;
    localparam int WORD           = 4;

    localparam logic [TW-1:0] TT_INC    = TW'(CLK_NS);
    localparam logic [TW-1:0] AR_STEP   = TW'(AR_STEP_NS);
    localparam logic [TW-1:0] STAT_MASK = ~TW'(STAT_RES_NS - 1);
    localparam logic [LW-1:0] LMASK_RST = 32'hffffffff;

    localparam logic [AW-1:0] CTRL_OFF  = 9'h000;
    localparam logic [AW-1:0] CFG_OFF   = 9'h004;
    localparam logic [AW-1:0] LMASK_OFF = 9'h008;
    localparam logic [AW-1:0] QVAL_OFF  = 9'h00c;
    localparam logic [AW-1:0] QCARE_OFF = 9'h010;
    localparam logic [AW-1:0] SVAL_OFF  = 9'h014;
    localparam logic [AW-1:0] SCARE_OFF = 9'h018;
    localparam logic [AW-1:0] EVAL_OFF  = 9'h01c;
    localparam logic [AW-1:0] ECARE_OFF = 9'h020;
    localparam logic [AW-1:0] HEN_OFF   = 9'h024;
    localparam logic [AW-1:0] STAT_OFF  = 9'h028;
    localparam logic [AW-1:0] HTOT_OFF  = 9'h02c;
    localparam logic [AW-1:0] OTH_OFF   = 9'h030;
    localparam logic [AW-1:0] ITOT_OFF  = 9'h034;
    localparam logic [AW-1:0] HR_BASE   = 9'h040;
    localparam logic [AW-1:0] HC_BASE   = 9'h0a0;
    localparam logic [AW-1:0] IR_BASE   = 9'h100;
    localparam logic [AW-1:0] IC_BASE   = 9'h180;
    localparam logic [AW-1:0] MIN_OFF   = 9'h1a0;
    localparam logic [AW-1:0] MAX_OFF   = 9'h1a8;
    localparam logic [AW-1:0] SUM_OFF   = 9'h1b0;
    localparam logic [AW-1:0] ARMIN_OFF = 9'h1c0;
    localparam logic [AW-1:0] ARMAX_OFF = 9'h1c8;

    localparam int CT_RUN  = 0;
    localparam int CT_STOP = 1;
    localparam int CT_AUTO = 2;
    localparam int CT_LOG  = 3;
    localparam int CF_MODE = 0;
    localparam int CF_QUAL = 1;
    localparam int CF_OTH  = 2;
    localparam int CF_HALF = 3;
    localparam int CF_SH   = 4;
    localparam int SH_W    = 5;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_ACQ    = 2'h1,
        ST_COMMIT = 2'h3
    } acq_st_t;

    typedef struct packed {
        logic          valid;
        logic [LW-1:0] data;
    } smp_t;

    typedef struct packed {
        logic          wr;
        logic          rd;
        logic [AW-1:0] addr;
        logic [31:0]   wdata;
    } bus_req_t;

    typedef struct packed {
        acq_st_t                  st;
        logic                     halted;
        logic                     timing;
        logic [31:0]              cfg;
        logic [LW-1:0]            lmask;
        logic [LW-1:0]            qv;
        logic [LW-1:0]            qc;
        logic [LW-1:0]            sv;
        logic [LW-1:0]            sc;
        logic [LW-1:0]            ev;
        logic [LW-1:0]            ec;
        logic [NHR-1:0]           hen;
        logic [NHR-1:0][LW-1:0]   hlo;
        logic [NHR-1:0][LW-1:0]   hhi;
        logic [NHR-1:0][CW-1:0]   hc;
        logic [CW-1:0]            oth;
        logic [CW-1:0]            htot;
        logic [CW-1:0]            itot;
        logic [CW-1:0]            ipend;
        logic [NIR-1:0][TW-1:0]   ilo;
        logic [NIR-1:0][TW-1:0]   ihi;
        logic [NIR-1:0][CW-1:0]   ic;
        logic [TW-1:0]            tt;
        logic [TW-1:0]            t0;
        logic [TW-1:0]            mn;
        logic [TW-1:0]            mx;
        logic [TW-1:0]            armin;
        logic [TW-1:0]            armax;
        logic [63:0]              sum;
        logic [NW-1:0]            nsmp;
        logic [31:0]              rdata;
    } engine_t;
endpackage

// [test/target_model.sv]
// target_model: stands in for the sampled target system
// assumes the bench asks for one state per send pulse
`timescale 1ns/100ps
`default_nettype none
module target_model
    import spa_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          send,
    input  wire logic [LW-1:0] val,
    output var  smp_t          smp
);
    // idle cycles show inverted data so a stale state never looks valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            smp <= '0;
        end else if (send) begin
            smp <= '{valid: 1'b1, data: val};
        end else begin
            smp <= '{valid: 1'b0, data: ~smp.data};
        end
    end
endmodule
`default_nettype wire

// [test/testbench.sv]
// testbench: register and sample checks of spa_engine
// assumes a 100 MHz clock and target_model as the sampled system
`timescale 1ns/100ps
`default_nettype none
module testbench import spa_pkg::*;;
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    bus_req_t      req = '0;
    logic          send = 1'b0;
    logic [LW-1:0] val = '0;
    smp_t          smp;
    logic [31:0]   rdata;
    logic          busy;
    logic          halted;
    int            n_mismatch = 0;
    int            cmp_count = 0;
    logic [31:0]   v4 [4];
    always #5 clk = ~clk;
    target_model i_tgt (.clk(clk), .rst_n(rst_n), .send(send), .val(val), .smp(smp));
    spa_engine i_dut (.clk(clk), .rst_n(rst_n), .req(req), .smp(smp), .rdata(rdata), .busy(busy),
                      .halted(halted));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask
    // read data live only in the cycle after the strobe
    task automatic rchk(input logic [AW-1:0] a, input logic [31:0] e);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        req <= '0;
        #1 chk(rdata, e);
    endtask
    task automatic put(input logic [LW-1:0] v);
        @(posedge clk);
        send <= 1'b1;
        val <= v;
        @(posedge clk);
        send <= 1'b0;
    endtask
    task automatic t_hist;
        v4 = '{32'ha, 32'h14, 32'hf, 32'h1e};
        for (int i = 0; i < 4; i++) begin
            wr(HR_BASE + AW'(4 * i), v4[i]);
        end
        wr(HR_BASE + 9'h10, 32'h28);
        wr(HR_BASE + 9'h14, 32'h32);
        wr(HEN_OFF, 32'h3);
        wr(CTRL_OFF, 32'h1);
        #1 chk({busy, halted}, 32'h2);
        v4 = '{32'hf, 32'h14, 32'h2d, 32'h9};
        foreach (v4[i]) put(v4[i]);
        put(32'ha);
        rchk(HC_BASE, 32'h3);
        rchk(HC_BASE + 9'h4, 32'h2);
        rchk(HC_BASE + 9'h8, 32'h0);
        rchk(HTOT_OFF, 32'h3);
        rchk(OTH_OFF, 32'h2);
        rchk(HR_BASE + 9'h10, 32'h28);
        $display("histogram test done");
    endtask
    task automatic t_qual;
        wr(CTRL_OFF, 32'h2);
        wr(LMASK_OFF, 32'hff);
        wr(QVAL_OFF, 32'h100);
        wr(QCARE_OFF, 32'h100);
        // label taken from bits 11:4, so only a working shift puts 10c in range 1
        wr(CFG_OFF, 32'h46);
        wr(CTRL_OFF, 32'h1);
        put(32'h10c);
        put(32'h00c);
        put(32'h1ff);
        rchk(HC_BASE, 32'h1);
        rchk(HC_BASE + 9'h4, 32'h1);
        rchk(OTH_OFF, 32'h1);
        rchk(HTOT_OFF, 32'h2);
        wr(CFG_OFF, 32'h0);
        #1 chk({busy, halted}, 32'h1);
        $display("qualify and halt test done");
    endtask
    task automatic t_intv;
        v4 = '{32'h1, 32'hffffffff, 32'h2, 32'hffffffff};
        for (int i = 0; i < 4; i++) begin
            wr(SVAL_OFF + AW'(4 * i), v4[i]);
        end
        v4 = '{32'h14, 32'h32, 32'h32, 32'h64};
        for (int i = 0; i < 4; i++) begin
            wr(IR_BASE + AW'(8 * i), v4[i]);
        end
        wr(CFG_OFF, 32'h1);
        wr(CTRL_OFF, 32'h1);
        put(32'h1);
        put(32'h1);
        @(posedge clk);
        put(32'h2);
        // a second start restarting the timer would land this in range 0
        rchk(IC_BASE, 32'h0);
        rchk(IC_BASE + 9'h4, 32'h1);
        rchk(ITOT_OFF, 32'h0);
        wr(CTRL_OFF, 32'h2);
        rchk(ITOT_OFF, 32'h1);
        rchk(MIN_OFF, 32'h30);
        rchk(MAX_OFF, 32'h30);
        $display("interval test done");
    endtask
    task automatic t_auto;
        wr(ARMAX_OFF, 32'h190);
        wr(CTRL_OFF, 32'h4);
        rchk(IR_BASE + 9'h70, 32'h15e);
        rchk(IR_BASE + 9'h78, 32'h190);
        wr(CTRL_OFF, 32'hc);
        rchk(IR_BASE + 9'h48, 32'h136);
        rchk(IR_BASE + 9'h50, 32'h0);
        wr(ARMAX_OFF, 32'h0);
        wr(CTRL_OFF, 32'h4);
        rchk(IR_BASE + 9'h48, 32'h0);
        // every range is off now, yet the pair still feeds the statistics
        wr(CTRL_OFF, 32'h1);
        put(32'h1);
        put(32'h2);
        put(32'h1);
        wr(CTRL_OFF, 32'h2);
        rchk(IC_BASE, 32'h0);
        rchk(ITOT_OFF, 32'h1);
        rchk(MIN_OFF, 32'h10);
        wr(CFG_OFF, 32'h9);
        wr(CTRL_OFF, 32'h1);
        put(32'h1);
        put(32'h2);
        rchk(STAT_OFF, 32'h1);
        wr(CTRL_OFF, 32'h2);
        rchk(ITOT_OFF, 32'h0);
        $display("auto-range and half-channel test done");
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rchk(LMASK_OFF, 32'hffffffff);
        chk({busy, halted}, 32'h0);
        t_hist;
        t_qual;
        t_intv;
        t_auto;
        give_verdict;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        give_verdict;
    end
endmodule
`default_nettype wire
